// file: adccfg_defs.svh
// register offsets, field positions, write masks and reset values of the
// converter configuration bank; definitions only, no logic.
`ifndef ADCCFG_DEFS_SVH
`define ADCCFG_DEFS_SVH

`define ADCCFG_OFF_GLOBAL 8'h00
`define ADCCFG_OFF_TUNING 8'h02
`define ADCCFG_OFF_FORMAT 8'h3c
`define ADCCFG_OFF_PAT_HIGH 8'h3e
`define ADCCFG_OFF_PAT_LOW 8'h3f
`define ADCCFG_OFF_REFPWR 8'h44
`define ADCCFG_OFF_GAIN 8'h45

`define ADCCFG_BIT_READBACK 0
`define ADCCFG_BIT_SW_INIT 1
`define ADCCFG_BIT_FMT_SRC 7
`define ADCCFG_BIT_FMT_SEL 6
`define ADCCFG_BIT_PDN 6
`define ADCCFG_BIT_REF_SRC 3
`define ADCCFG_BIT_REF_SEL 2

// writable bits per register; all other bits read as zero
`define ADCCFG_MASK_GLOBAL 8'h01
`define ADCCFG_MASK_TUNING 8'h71
`define ADCCFG_MASK_FORMAT 8'hc0
`define ADCCFG_MASK_PAT_HIGH 8'hff
`define ADCCFG_MASK_PAT_LOW 8'hfc
`define ADCCFG_MASK_REFPWR 8'h4c
`define ADCCFG_MASK_GAIN 8'hf0

`define ADCCFG_RST_REG 8'h00

// serial framing: address bits, then data bits, word commits on last bit
`define ADCCFG_ADDR_LAST 4'h7
`define ADCCFG_WORD_LAST 4'hf

`endif

// file: adccfg_pkg.sv
// types shared by the converter configuration bank.
// assumes the defs header is compiled alongside.
package adccfg_pkg;
   // direction of the serial port, chosen by the readback bit
   typedef enum logic [0:0] {
      ADCCFG_WRITE = 1'b0,
      ADCCFG_READ = 1'b1
   } adccfg_dir_t;
endpackage : adccfg_pkg

// file: adccfg_sync.sv
// two-stage synchroniser for a group of asynchronous input levels.
// assumes one clock; only the second stage is visible outside.
`timescale 1ns/1ps
`default_nettype none
module adccfg_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_q;

   // the first stage feeds only the second stage
   always_comb begin
      next_meta = d;
      next_q = meta;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         meta <= RST;
         q <= RST;
      end else begin
         meta <= next_meta;
         q <= next_q;
      end
   end
endmodule : adccfg_sync
`default_nettype wire

// file: adccfg_bank.sv
// configuration register bank of a single-channel converter, reached
// over a three-wire serial port. assumes serial clock well below a
// quarter of clk_sys, since all pins are oversampled on clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "adccfg_defs.svh"

module adccfg_bank (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic serial_clk,
   input wire logic serial_select_n,
   input wire logic serial_in_line,
   output logic serial_out_pin,
   input wire logic shared_config_pin_format,
   input wire logic shared_config_pin_extref,
   output adccfg_pkg::adccfg_dir_t port_direction,
   output logic [3:0] distortion_tuning_bits,
   output logic format_offset_binary,
   output logic [13:0] user_test_pattern,
   output logic reference_external,
   output logic power_down_bit,
   output logic [3:0] fine_gain
);
   import adccfg_pkg::*;

   logic s_sclk, s_sen_n, s_sdi, s_fmt_pin, s_ref_pin;
   logic sclk_prev, next_sclk_prev;
   logic [15:0] shift, next_shift;
   logic [3:0] cnt, next_cnt;
   logic [7:0] rd_shift, next_rd_shift;
   logic sdo, next_sdo;
   logic sw_init, next_sw_init;
   logic [7:0] global_control, next_global_control;
   logic [7:0] distortion_tuning, next_distortion_tuning;
   logic [7:0] output_format_control, next_output_format_control;
   logic [7:0] user_pattern_high, next_user_pattern_high;
   logic [7:0] user_pattern_low, next_user_pattern_low;
   logic [7:0] reference_power_control, next_reference_power_control;
   logic [7:0] gain_control, next_gain_control;
   logic fmt_out, next_fmt_out, ref_out, next_ref_out;
   logic fall, commit;
   logic [15:0] word;
   logic [7:0] rd_value;

   // every pin crosses two flops; shift clock and select idle high, so
   // they reset high too and no false fall or frame follows a reset
   adccfg_sync #(.W(5), .RST(5'h18)) u_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .d({serial_clk, serial_select_n, serial_in_line,
          shared_config_pin_format, shared_config_pin_extref}),
      .q({s_sclk, s_sen_n, s_sdi, s_fmt_pin, s_ref_pin})
   );

   // falling serial clock inside a frame, and the word seen with this bit
   assign fall = sclk_prev & ~s_sclk & ~s_sen_n;
   assign word = {shift[14:0], s_sdi};
   assign commit = fall && (cnt == `ADCCFG_WORD_LAST);

   // readback mux on the address just shifted in; unmapped reads as zero
   always_comb begin
      rd_value = 8'h00;
      if (word[7:0] == `ADCCFG_OFF_GLOBAL) begin
         rd_value = global_control;
      end else if (word[7:0] == `ADCCFG_OFF_TUNING) begin
         rd_value = distortion_tuning;
      end else if (word[7:0] == `ADCCFG_OFF_FORMAT) begin
         rd_value = output_format_control;
      end else if (word[7:0] == `ADCCFG_OFF_PAT_HIGH) begin
         rd_value = user_pattern_high;
      end else if (word[7:0] == `ADCCFG_OFF_PAT_LOW) begin
         rd_value = user_pattern_low;
      end else if (word[7:0] == `ADCCFG_OFF_REFPWR) begin
         rd_value = reference_power_control;
      end else if (word[7:0] == `ADCCFG_OFF_GAIN) begin
         rd_value = gain_control;
      end
   end

   // serial shifter: bit count restarts whenever select goes high, so a
   // trailing partial word is dropped and back-to-back words are fine
   always_comb begin
      next_sclk_prev = s_sclk;
      next_shift = shift;
      next_cnt = cnt;
      next_rd_shift = rd_shift;
      next_sdo = sdo;
      if (s_sen_n) begin
         next_cnt = 4'h0;
         next_sdo = 1'b0;
      end else if (fall) begin
         next_shift = word;
         next_cnt = cnt + 4'h1;
         if (cnt == `ADCCFG_ADDR_LAST && global_control[0]) begin
            // present msb now so the controller latches it next fall
            next_sdo = rd_value[7];
            next_rd_shift = {rd_value[6:0], 1'b0};
         end else if (cnt > `ADCCFG_ADDR_LAST) begin
            next_sdo = rd_shift[7];
            next_rd_shift = {rd_shift[6:0], 1'b0};
         end
      end
   end

   // register file; software init beats a commit in the same cycle
   always_comb begin
      next_global_control = global_control;
      next_distortion_tuning = distortion_tuning;
      next_output_format_control = output_format_control;
      next_user_pattern_high = user_pattern_high;
      next_user_pattern_low = user_pattern_low;
      next_reference_power_control = reference_power_control;
      next_gain_control = gain_control;
      next_sw_init = 1'b0;
      if (sw_init) begin
         next_global_control = `ADCCFG_RST_REG;
         next_distortion_tuning = `ADCCFG_RST_REG;
         next_output_format_control = `ADCCFG_RST_REG;
         next_user_pattern_high = `ADCCFG_RST_REG;
         next_user_pattern_low = `ADCCFG_RST_REG;
         next_reference_power_control = `ADCCFG_RST_REG;
         next_gain_control = `ADCCFG_RST_REG;
      end else if (commit && global_control[0]) begin
         // readback: only the direction bit may change
         if (word[15:8] == `ADCCFG_OFF_GLOBAL) begin
            next_global_control = word[7:0] & `ADCCFG_MASK_GLOBAL;
         end
      end else if (commit) begin
         if (word[15:8] == `ADCCFG_OFF_GLOBAL) begin
            next_global_control = word[7:0] & `ADCCFG_MASK_GLOBAL;
            next_sw_init = word[`ADCCFG_BIT_SW_INIT];
         end else if (word[15:8] == `ADCCFG_OFF_TUNING) begin
            next_distortion_tuning = word[7:0] & `ADCCFG_MASK_TUNING;
         end else if (word[15:8] == `ADCCFG_OFF_FORMAT) begin
            next_output_format_control = word[7:0] & `ADCCFG_MASK_FORMAT;
         end else if (word[15:8] == `ADCCFG_OFF_PAT_HIGH) begin
            next_user_pattern_high = word[7:0];
         end else if (word[15:8] == `ADCCFG_OFF_PAT_LOW) begin
            next_user_pattern_low = word[7:0] & `ADCCFG_MASK_PAT_LOW;
         end else if (word[15:8] == `ADCCFG_OFF_REFPWR) begin
            next_reference_power_control = word[7:0] & `ADCCFG_MASK_REFPWR;
         end else if (word[15:8] == `ADCCFG_OFF_GAIN) begin
            next_gain_control = word[7:0] & `ADCCFG_MASK_GAIN;
         end
      end
   end

   // pin-or-register overrides, registered so the outputs are clean
   always_comb begin
      next_fmt_out = output_format_control[`ADCCFG_BIT_FMT_SRC] ?
         output_format_control[`ADCCFG_BIT_FMT_SEL] : s_fmt_pin;
      next_ref_out = reference_power_control[`ADCCFG_BIT_REF_SRC] ?
         reference_power_control[`ADCCFG_BIT_REF_SEL] : s_ref_pin;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sclk_prev <= 1'b1;
         shift <= 16'h0000;
         cnt <= 4'h0;
         rd_shift <= 8'h00;
         sdo <= 1'b0;
         sw_init <= 1'b0;
         global_control <= `ADCCFG_RST_REG;
         distortion_tuning <= `ADCCFG_RST_REG;
         output_format_control <= `ADCCFG_RST_REG;
         user_pattern_high <= `ADCCFG_RST_REG;
         user_pattern_low <= `ADCCFG_RST_REG;
         reference_power_control <= `ADCCFG_RST_REG;
         gain_control <= `ADCCFG_RST_REG;
         fmt_out <= 1'b0;
         ref_out <= 1'b0;
      end else begin
         sclk_prev <= next_sclk_prev;
         shift <= next_shift;
         cnt <= next_cnt;
         rd_shift <= next_rd_shift;
         sdo <= next_sdo;
         sw_init <= next_sw_init;
         global_control <= next_global_control;
         distortion_tuning <= next_distortion_tuning;
         output_format_control <= next_output_format_control;
         user_pattern_high <= next_user_pattern_high;
         user_pattern_low <= next_user_pattern_low;
         reference_power_control <= next_reference_power_control;
         gain_control <= next_gain_control;
         fmt_out <= next_fmt_out;
         ref_out <= next_ref_out;
      end
   end

   // field outputs follow the stored values
   assign port_direction = adccfg_dir_t'(global_control[0]);
   assign distortion_tuning_bits = {distortion_tuning[6:4],
                                    distortion_tuning[0]};
   assign user_test_pattern = {user_pattern_high,
                               user_pattern_low[7:2]};
   assign power_down_bit = reference_power_control[`ADCCFG_BIT_PDN];
   assign fine_gain = gain_control[7:4];
   assign format_offset_binary = fmt_out;
   assign reference_external = ref_out;
   assign serial_out_pin = sdo;

   AST_SW_INIT: assert property (@(posedge clk_sys) disable iff (!rst_n)
      sw_init |=> (user_test_pattern == 14'h0000) && (fine_gain == 4'h0)
         && !sw_init && (global_control == 8'h00))
      else $error("software init did not restore defaults");
   AST_INIT_SET: assert property (@(posedge clk_sys) disable iff (!rst_n)
      commit && !global_control[0] && word[15:8] == 8'h00 && word[1]
      |=> sw_init ##1 (gain_control == 8'h00))
      else $error("init bit write did not reset the bank");
   AST_RD_LOCK: assert property (@(posedge clk_sys) disable iff (!rst_n)
      commit && global_control[0] && word[15:8] != 8'h00 && !sw_init
      |=> $stable(user_test_pattern) && $stable(fine_gain))
      else $error("write accepted in readback mode");
   AST_FMT: assert property (@(posedge clk_sys) disable iff (!rst_n)
      output_format_control[7] |=>
         format_offset_binary == $past(output_format_control[6]))
      else $error("format output ignores register select");
   AST_REF_PIN: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !reference_power_control[3] |=> reference_external == $past(s_ref_pin))
      else $error("reference output ignores pin");
   AST_PAT_LOW: assert property (@(posedge clk_sys) disable iff (!rst_n)
      commit && !global_control[0] && !sw_init && word[15:8] == 8'h3f
      |=> user_test_pattern[5:0] == $past(word[7:2]))
      else $error("pattern low bits not stored");
   AST_GAIN: assert property (@(posedge clk_sys) disable iff (!rst_n)
      commit && !global_control[0] && !sw_init && word[15:8] == 8'h45
      |=> fine_gain == $past(word[7:4]))
      else $error("gain not stored");
   AST_FRAME: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_sen_n |=> cnt == 4'h0 && !serial_out_pin)
      else $error("bit count not cleared outside frame");
   AST_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !commit && !sw_init |=> $stable(user_pattern_high)
         && $stable(reference_power_control))
      else $error("field changed without a write");
   AST_SDO: assert property (@(posedge clk_sys) disable iff (!rst_n)
      fall && global_control[0] && cnt == 4'h7
      |=> serial_out_pin == $past(rd_value[7]))
      else $error("readback msb not presented");
endmodule : adccfg_bank
`default_nettype wire

// file: adccfg_ctrl_model.sv
// controller model for the three-wire configuration port of the bank.
// assumes a free-running clk_sys; the shift clock is derived from it.
`timescale 1ns/1ps
`default_nettype none
module adccfg_ctrl_model (
   input wire logic clk_sys,
   output logic serial_clk,
   output logic serial_select_n,
   output logic serial_in_line,
   input wire logic serial_out_pin
);
   // half period in clk_sys cycles; raise it to act as a slow controller
   int hp = 5;

   // shift clock stands high between frames, nothing is selected
   initial begin
      serial_clk = 1'b1;
      serial_select_n = 1'b1;
      serial_in_line = 1'b0;
   end

   // shift n bits msb first; readback is sampled just before each fall,
   // so rd ends up holding the data byte of the last word
   task automatic xfer(input logic [31:0] bits, input int n,
      output logic [7:0] rd);
      rd = 8'h00;
      @(posedge clk_sys) serial_select_n <= 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         @(posedge clk_sys) serial_in_line <= bits[i];
         repeat (hp - 1) @(posedge clk_sys);
         @(negedge clk_sys) rd = {rd[6:0], serial_out_pin};
         @(posedge clk_sys) serial_clk <= 1'b0;
         repeat (hp) @(posedge clk_sys);
         serial_clk <= 1'b1;
      end
      repeat (hp) @(posedge clk_sys);
      serial_select_n <= 1'b1;
      // released data line must not keep showing its last bit
      serial_in_line <= ~bits[0];
      repeat (hp) @(posedge clk_sys);
   endtask : xfer
endmodule : adccfg_ctrl_model
`default_nettype wire

// file: adc_config_register_bank_tb.sv
// self-checking bench for the converter configuration bank.
// assumes the controller model drives the serial port side.
`timescale 1ns/1ps
`default_nettype none
module adc_config_register_bank_tb;
   import adccfg_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic pin_fmt = 1'b0;
   logic pin_ref = 1'b0;
   wire logic serial_clk;
   wire logic serial_select_n;
   wire logic serial_in_line;
   wire logic serial_out_pin;
   adccfg_dir_t port_direction;
   logic [3:0] tuning;
   logic [3:0] gain;
   logic [13:0] pattern;
   logic fmt_ob;
   logic ref_ext;
   logic pdn;
   logic [7:0] rd;
   int n_fail = 0;
   int compares = 0;

   // 10 MHz system clock
   always #50 clk_sys = ~clk_sys;

   adccfg_bank DUT (
      .clk_sys(clk_sys), .rst_n(rst_n), .serial_clk(serial_clk),
      .serial_select_n(serial_select_n), .serial_in_line(serial_in_line),
      .serial_out_pin(serial_out_pin), .shared_config_pin_format(pin_fmt),
      .shared_config_pin_extref(pin_ref), .port_direction(port_direction),
      .distortion_tuning_bits(tuning), .format_offset_binary(fmt_ob),
      .user_test_pattern(pattern), .reference_external(ref_ext),
      .power_down_bit(pdn), .fine_gain(gain)
   );

   adccfg_ctrl_model ctrl (
      .clk_sys(clk_sys), .serial_clk(serial_clk),
      .serial_select_n(serial_select_n), .serial_in_line(serial_in_line),
      .serial_out_pin(serial_out_pin)
   );

   task automatic end_of_test;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_of_test

   // compare an output port value
   task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t output %h expected %h", $time, got, exp);
      end
   endtask : chk_out

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      ctrl.xfer({16'h0000, a, d}, 16, rd);
   endtask : wr

   // read one register back and compare the shifted-out byte
   task automatic chk_rd(input logic [7:0] a, input logic [7:0] d,
      input logic [7:0] exp);
      ctrl.xfer({16'h0000, a, d}, 16, rd);
      compares++;
      if (rd !== exp) begin
         n_fail++;
         $display("BAD %0t read %h gave %h expected %h", $time, a, rd, exp);
      end
   endtask : chk_rd

   // watchdog: a hung run still reaches the verdict
   initial begin
      repeat (50000) @(posedge clk_sys);
      n_fail++;
      $display("BAD %0t run did not finish", $time);
      end_of_test();
   end

   initial begin
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      pin_fmt <= 1'b1;
      pin_ref <= 1'b1;
      repeat (6) @(posedge clk_sys);
      chk_out(16'(port_direction), 16'(ADCCFG_WRITE));
      chk_out(16'({gain, tuning}), 16'h0000);
      chk_out(16'({fmt_ob, ref_ext}), 16'h0003);
      wr(8'h3c, 8'h80);
      chk_out(16'(fmt_ob), 16'h0000);
      wr(8'h3c, 8'hc0);
      chk_out(16'(fmt_ob), 16'h0001);
      wr(8'h44, 8'h08);
      chk_out(16'(ref_ext), 16'h0000);
      wr(8'h44, 8'h4c);
      chk_out(16'({pdn, ref_ext}), 16'h0003);
      // pin takes over again; register format bit must be ignored
      wr(8'h3c, 8'h40);
      pin_fmt <= 1'b0;
      repeat (6) @(posedge clk_sys);
      chk_out(16'(fmt_ob), 16'h0000);
      wr(8'h02, 8'h71);
      chk_out(16'(tuning), 16'h000f);
      wr(8'h02, 8'h50);
      chk_out(16'(tuning), 16'h000a);
      // two words in one frame; low pattern bits 1:0 are ignored
      ctrl.xfer({8'h3e, 8'h11, 8'h3f, 8'h87}, 32, rd);
      chk_out(16'(pattern), 16'h0461);
      for (int g = 0; g <= 12; g++) begin
         wr(8'h45, {g[3:0], 4'h5});
         chk_out(16'(gain), 16'(g));
      end
      // slow controller, one word plus eight excess bits
      ctrl.hp = 9;
      ctrl.xfer({8'h00, 8'h45, 8'h30, 8'h45}, 24, rd);
      ctrl.hp = 5;
      chk_out(16'(gain), 16'h0003);
      wr(8'h00, 8'h01);
      chk_out(16'(port_direction), 16'(ADCCFG_READ));
      chk_rd(8'h3e, 8'h00, 8'h11);
      chk_rd(8'h3f, 8'h00, 8'h84);
      chk_rd(8'h44, 8'h00, 8'h4c);
      chk_rd(8'h45, 8'hf0, 8'h30);
      chk_rd(8'h02, 8'h00, 8'h50);
      chk_rd(8'h3c, 8'h00, 8'h40);
      chk_rd(8'h10, 8'h00, 8'h00);
      chk_out(16'(gain), 16'h0003);
      // init refused in readback, only the direction bit is taken
      wr(8'h00, 8'h02);
      chk_out(16'({port_direction, gain}), 16'h0003);
      pin_fmt <= 1'b1;
      pin_ref <= 1'b0;
      wr(8'h00, 8'h02);
      chk_out(16'({gain, tuning, pdn}), 16'h0000);
      chk_out(16'(pattern), 16'h0000);
      chk_out(16'({fmt_ob, ref_ext}), 16'h0002);
      wr(8'h00, 8'h01);
      chk_rd(8'h00, 8'h01, 8'h01);
      wr(8'h00, 8'h00);
      chk_out(16'(port_direction), 16'(ADCCFG_WRITE));
      wr(8'h45, 8'h70);
      chk_out(16'(gain), 16'h0007);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk_sys);
      chk_out(16'(gain), 16'h0000);
      end_of_test();
   end
endmodule : adc_config_register_bank_tb
`default_nettype wire
